// file: pkg/io_port_pkg.sv
// constants for the six-bit i/o port block
package io_port_pkg;
    localparam int PORT_W = 8;
    localparam int PIN_N = 6;
    localparam logic [7:0] UNIMPL_MASK = 8'h3f;
    localparam logic [5:0] DIR_RESET = 6'h3f;
    localparam logic [5:0] LATCH_RESET = 6'h00;
    localparam int INPUT_ONLY_BIT = 3;
    localparam int TIMER_PIN_BIT = 5;
    // primary pins sharing pull-up and wake-on-change
    localparam logic [5:0] SHARED_PIN_MASK = 6'h1b;
    localparam logic [5:0] INPUT_ONLY_MASK = 6'h08;
    localparam logic [5:0] TIMER_PIN_MASK = 6'h20;
endpackage

// file: verilog/pin_cell.sv
// one port pin: synchroniser, latch, driver control
`timescale 1ns/10ps
module pin_cell (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // core side
    input wire logic latch_we_i,
    input wire logic latch_d_i,
    input wire logic dir_we_i,
    input wire logic dir_d_i,
    input wire logic force_input_i,
    // pin side
    input wire logic pin_i,
    output logic pin_sync_o,
    output logic pin_o,
    output logic pin_oe_o
);
    logic sync_a;
    logic latch;
    logic dir;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            sync_a <= 1'b0;
            pin_sync_o <= 1'b0;
        end
        else
        begin
            sync_a <= pin_i;
            pin_sync_o <= sync_a;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            latch <= 1'b0;
        else if (latch_we_i)
            latch <= latch_d_i;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            dir <= 1'b1;
        else if (dir_we_i)
            dir <= dir_d_i;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pin_o <= 1'b0;
            pin_oe_o <= 1'b0;
        end
        else
        begin
            pin_o <= latch_we_i ? latch_d_i : latch;
            pin_oe_o <= ~(dir_we_i ? dir_d_i : dir) & ~force_input_i;
        end
    end
endmodule // pin_cell

// file: verilog/six_bit_io_port.sv
// two six-bit general purpose i/o ports with direction control
`timescale 1ns/10ps
// Functional notes
// - port reads return pin levels, never latch contents
// - on reset every pin is an input with driver off
// - direction registers are write-only and reset to all ones
// - primary port bits 7 and 6 read zero
// - secondary port bits 7 and 6 read zero
// - alternate-function pins read zero
// - pull-up and wake-on-change shared on primary pins 0,1,3,4
// - master clear on pin 3: pull-up forced on, wake disabled
// - direction-load copies working register to direction register
// - direction one tristates, zero drives latch onto pin
// - pin 3 input only; timer option may override timer pin
// - output latches hold until rewritten
// - timer clock input active on secondary pin 5 while timer_pin_sel_i is set
// - other pins individually configurable in or out
module six_bit_io_port (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // core access
    input wire logic pri_wr_i,
    input wire logic sec_wr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic pri_dir_load_i,
    input wire logic sec_dir_load_i,
    input wire logic [7:0] work_reg_i,
    output logic [7:0] pri_rd_o,
    output logic [7:0] sec_rd_o,
    // configuration
    input wire logic [5:0] pri_alt_i,
    input wire logic [5:0] sec_alt_i,
    input wire logic master_clear_en_i,
    input wire logic pullup_en_i,
    input wire logic wake_en_i,
    input wire logic timer_pin_sel_i,
    // pins
    input wire logic [5:0] pri_pin_i,
    output logic [5:0] pri_pin_o,
    output logic [5:0] pri_pin_oe_o,
    input wire logic [5:0] sec_pin_i,
    output logic [5:0] sec_pin_o,
    output logic [5:0] sec_pin_oe_o,
    // shared pin features
    output logic [5:0] pri_pullup_o,
    output logic wake_o
);
    logic [5:0] pri_sync;
    logic [5:0] sec_sync;
    logic [5:0] pri_force;
    logic [5:0] sec_force;
    logic [5:0] wake_ref;
    logic [5:0] next_pullup;
    logic [5:0] wake_mask;
    logic [2:0] wake_settle;

    assign pri_force = io_port_pkg::INPUT_ONLY_MASK;
    // timer input claims secondary pin five
    assign sec_force = timer_pin_sel_i ? io_port_pkg::TIMER_PIN_MASK : 6'h00;

    genvar g;
    generate
        for (g = 0; g < io_port_pkg::PIN_N; g++)
        begin : gen_pins
            pin_cell pri_cell (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .latch_we_i(pri_wr_i),
                .latch_d_i(wr_data_i[g]),
                .dir_we_i(pri_dir_load_i),
                .dir_d_i(work_reg_i[g]),
                .force_input_i(pri_force[g]),
                .pin_i(pri_pin_i[g]),
                .pin_sync_o(pri_sync[g]),
                .pin_o(pri_pin_o[g]),
                .pin_oe_o(pri_pin_oe_o[g])
            );
            pin_cell sec_cell (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .latch_we_i(sec_wr_i),
                .latch_d_i(wr_data_i[g]),
                .dir_we_i(sec_dir_load_i),
                .dir_d_i(work_reg_i[g]),
                .force_input_i(sec_force[g]),
                .pin_i(sec_pin_i[g]),
                .pin_sync_o(sec_sync[g]),
                .pin_o(sec_pin_o[g]),
                .pin_oe_o(sec_pin_oe_o[g])
            );
        end
    endgenerate

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            pri_rd_o <= 8'h00;
            sec_rd_o <= 8'h00;
        end
        else
        begin
            // upper bits zero, alternate pins zero
            pri_rd_o <= {2'b00, pri_sync & ~pri_alt_i};
            sec_rd_o <= {2'b00, sec_sync & ~sec_alt_i};
        end
    end

    // shared pull-up, forced on pin 3 under master clear
    always_comb
    begin
        next_pullup = pullup_en_i ? io_port_pkg::SHARED_PIN_MASK : 6'h00;
        if (master_clear_en_i)
            next_pullup = next_pullup | io_port_pkg::INPUT_ONLY_MASK;
    end

    // pin 3 excluded from wake under master clear
    assign wake_mask = master_clear_en_i ?
        (io_port_pkg::SHARED_PIN_MASK & ~io_port_pkg::INPUT_ONLY_MASK) :
        io_port_pkg::SHARED_PIN_MASK;

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
            pri_pullup_o <= 6'h00;
        else
            pri_pullup_o <= next_pullup;
    end

    // wake on change of shared pins over one cycle
    // settle chain keeps the post-reset synchroniser fill from faking a change
    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            wake_settle <= 3'h0;
            wake_ref <= 6'h00;
            wake_o <= 1'b0;
        end
        else
        begin
            wake_settle <= {wake_settle[1:0], 1'b1};
            wake_ref <= pri_sync;
            wake_o <= wake_en_i & wake_settle[2] & |((pri_sync ^ wake_ref) & wake_mask);
        end
    end

    a_read_pins: assert property (@(posedge clk_i) disable iff (rst_i)
        ##1 pri_rd_o[5:0] == ($past(pri_sync) & ~$past(pri_alt_i)))
        else $error("primary read does not follow pins");
    a_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        pri_rd_o[7:6] == 2'b00 && sec_rd_o[7:6] == 2'b00)
        else $error("unimplemented bits not zero");
    a_pin3_input: assert property (@(posedge clk_i) disable iff (rst_i)
        !pri_pin_oe_o[3])
        else $error("pin three driven");
    a_dir_load: assert property (@(posedge clk_i) disable iff (rst_i)
        pri_dir_load_i && !work_reg_i[0] |=> pri_pin_oe_o[0])
        else $error("direction load did not enable driver");
    a_dir_off: assert property (@(posedge clk_i) disable iff (rst_i)
        sec_dir_load_i && work_reg_i[1] |=> !sec_pin_oe_o[1])
        else $error("driver not released");
    a_latch_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        pri_wr_i |=> pri_pin_o[0] == $past(wr_data_i[0]))
        else $error("latch value not on pin");
    a_latch_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !sec_wr_i ##1 !sec_wr_i |-> $stable(sec_pin_o))
        else $error("latch changed without write");
    a_clear_pull: assert property (@(posedge clk_i) disable iff (rst_i)
        master_clear_en_i |=> pri_pullup_o[3])
        else $error("pin three pull-up off under master clear");
    a_timer_pin: assert property (@(posedge clk_i) disable iff (rst_i)
        timer_pin_sel_i |=> !sec_pin_oe_o[5])
        else $error("timer pin driven");
    a_pull_shared: assert property (@(posedge clk_i) disable iff (rst_i)
        !master_clear_en_i |=>
        pri_pullup_o == ({6{$past(pullup_en_i)}} & io_port_pkg::SHARED_PIN_MASK))
        else $error("pull-up not shared");

    c_drive: cover property (@(posedge clk_i) pri_dir_load_i ##1 pri_pin_oe_o[0]);
    c_wake: cover property (@(posedge clk_i) wake_o);
    c_alt: cover property (@(posedge clk_i) |pri_alt_i && |pri_sync);
endmodule // six_bit_io_port

// file: tb/pin_world.sv
// outside circuitry on one six-pin port: drivers, pull-ups, floating pins
`timescale 1ns/10ps
module pin_world (
    // clock
    input wire logic clk_i,
    // outside drivers
    input wire logic [5:0] ext_d_i,
    input wire logic [5:0] ext_en_i,
    // device side
    input wire logic [5:0] dev_d_i,
    input wire logic [5:0] dev_oe_i,
    input wire logic [5:0] pull_i,
    // resolved pin level
    output logic [5:0] lvl_o
);
    logic [5:0] flt = 6'h15;
    // undriven pins wander so a stale level cannot pass a read
    always @(posedge clk_i)
        flt <= ~flt;
    always_comb
        for (int b = 0; b < 6; b++)
            lvl_o[b] = dev_oe_i[b] ? dev_d_i[b] : ext_en_i[b] ? ext_d_i[b] :
                pull_i[b] ? 1'b1 : flt[b];
endmodule // pin_world

// file: tb/six_bit_io_port_tb.sv
// self-checking bench for the six-bit i/o port
`timescale 1ns/10ps
module six_bit_io_port_tb;
    typedef struct {int sel; logic [7:0] v; int due;} note_s;
    note_s q[$];
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic pri_wr_i = 1'b0, sec_wr_i = 1'b0, pri_dir_load_i = 1'b0, sec_dir_load_i = 1'b0;
    logic master_clear_en_i = 1'b0, pullup_en_i = 1'b0, wake_en_i = 1'b0, timer_pin_sel_i = 1'b1;
    logic [7:0] wr_data_i = 8'h00, work_reg_i = 8'h00, pri_rd_o, sec_rd_o, pd, sd, dat;
    logic [5:0] pri_alt_i = 6'h00, sec_alt_i = 6'h00, pri_pin_i, sec_pin_i, pri_pin_o;
    logic [5:0] sec_pin_o, pri_pin_oe_o, sec_pin_oe_o, pri_pullup_o, ext_d = 6'h00;
    logic [5:0] ext_en = 6'h00, pa, sa, poe, soe;
    logic wake_o;
    int seed = 32'h803e9298;
    int cyc = 0, bad_count = 0, tests_run = 0;

    six_bit_io_port dut (.clk_i(clk_i), .rst_i(rst_i), .pri_wr_i(pri_wr_i), .sec_wr_i(sec_wr_i),
        .wr_data_i(wr_data_i), .pri_dir_load_i(pri_dir_load_i), .sec_dir_load_i(sec_dir_load_i),
        .work_reg_i(work_reg_i), .pri_rd_o(pri_rd_o), .sec_rd_o(sec_rd_o), .pri_alt_i(pri_alt_i),
        .sec_alt_i(sec_alt_i), .master_clear_en_i(master_clear_en_i), .pullup_en_i(pullup_en_i),
        .wake_en_i(wake_en_i), .timer_pin_sel_i(timer_pin_sel_i), .pri_pin_i(pri_pin_i),
        .pri_pin_o(pri_pin_o), .pri_pin_oe_o(pri_pin_oe_o), .sec_pin_i(sec_pin_i),
        .sec_pin_o(sec_pin_o), .sec_pin_oe_o(sec_pin_oe_o), .pri_pullup_o(pri_pullup_o),
        .wake_o(wake_o));
    pin_world pri_w (.clk_i(clk_i), .ext_d_i(ext_d), .ext_en_i(ext_en), .dev_d_i(pri_pin_o),
        .dev_oe_i(pri_pin_oe_o), .pull_i(pri_pullup_o), .lvl_o(pri_pin_i));
    pin_world sec_w (.clk_i(clk_i), .ext_d_i(ext_d), .ext_en_i(ext_en), .dev_d_i(sec_pin_o),
        .dev_oe_i(sec_pin_oe_o), .pull_i(6'h00), .lvl_o(sec_pin_i));

    always #5 clk_i = ~clk_i;

    function automatic logic [7:0] got(int sel);
        case (sel)
            0: return pri_rd_o;
            1: return sec_rd_o;
            2: return {2'b00, pri_pin_oe_o};
            3: return {2'b00, sec_pin_oe_o};
            4: return {2'b00, pri_pin_o};
            5: return {2'b00, sec_pin_o};
            7: return {7'h00, wake_o};
            default: return {2'b00, pri_pullup_o};
        endcase
    endfunction

    task automatic check(logic [7:0] g, logic [7:0] e);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic note(int sel, logic [7:0] v);
        q.push_back('{sel, v, cyc + 1});
    endtask

    task automatic wrap_up;
        // a note never compared counts against the run
        if (q.size() > 0)
            bad_count++;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // oldest note is compared once its cycle comes up
    always @(negedge clk_i)
    begin : mon
        note_s n;
        cyc = cyc + 1;
        while (q.size() > 0 && q[0].due == cyc)
        begin
            n = q.pop_front();
            check(got(n.sel), n.v);
        end
    end

    initial
    begin
        repeat (1000) @(posedge clk_i);
        bad_count++;
        wrap_up();
    end

    initial
    begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        note(2, 8'h00);
        note(3, 8'h00);
        for (int i = 0; i < 16; i++)
        begin
            pd = $random(seed);
            sd = $random(seed);
            dat = $random(seed);
            pa = $random(seed);
            sa = ~pa | (i[0] ? 6'h20 : 6'h00);
            pa = pa | (i[2] ? 6'h08 : 6'h00);
            pri_dir_load_i <= 1'b1;
            sec_dir_load_i <= 1'b1;
            work_reg_i <= pd;
            timer_pin_sel_i <= i[0];
            @(posedge clk_i);
            // back-to-back loads: secondary keeps the later value
            pri_dir_load_i <= 1'b0;
            work_reg_i <= sd;
            @(posedge clk_i);
            sec_dir_load_i <= 1'b0;
            pri_wr_i <= 1'b1;
            sec_wr_i <= 1'b1;
            wr_data_i <= dat;
            @(posedge clk_i);
            pri_wr_i <= 1'b0;
            sec_wr_i <= 1'b0;
            wr_data_i <= ~dat;
            ext_d <= $random(seed);
            ext_en <= 6'h3f;
            pri_alt_i <= pa;
            sec_alt_i <= sa;
            pullup_en_i <= i[1];
            master_clear_en_i <= i[2];
            wake_en_i <= i[3];
            repeat (6) @(posedge clk_i);
            poe = ~pd[5:0] & 6'h37;
            soe = ~sd[5:0] & (i[0] ? 6'h1f : 6'h3f);
            note(2, {2'b00, poe});
            note(3, {2'b00, soe});
            note(4, {2'b00, dat[5:0]});
            note(5, {2'b00, dat[5:0]});
            note(0, {2'b00, (poe & dat[5:0] | ~poe & ext_d) & ~pa});
            note(1, {2'b00, (soe & dat[5:0] | ~soe & ext_d) & ~sa});
            note(6, {2'b00, (i[1] ? 6'h1b : 6'h00) | (i[2] ? 6'h08 : 6'h00)});
            @(posedge clk_i);
            ext_en <= $random(seed);
        end
        // wake: all inputs, quiet, then pins 2,3,5 move (no wake), then pin 0
        @(posedge clk_i);
        pri_dir_load_i <= 1'b1;
        work_reg_i <= 8'hff;
        ext_en <= 6'h3f;
        ext_d <= 6'h00;
        wake_en_i <= 1'b1;
        master_clear_en_i <= 1'b1;
        @(posedge clk_i);
        pri_dir_load_i <= 1'b0;
        repeat (5) @(posedge clk_i);
        ext_d <= 6'h2c;
        for (int j = 1; j <= 8; j++)
        begin
            @(posedge clk_i);
            if (j == 4)
                ext_d <= 6'h2d;
            note(7, {7'h00, j == 7});
        end
        repeat (2) @(posedge clk_i);
        wrap_up();
    end
endmodule // six_bit_io_port_tb
